// ===== verilog/oqr_seq.sv
// serial command sequencer: otp areas, read parameters, wrap reads, four-wire mode
`timescale 1ns/1ps
`include "oqr_map.svh"
module oqr_seq import oqr_pkg::*; (
   input  wire logic        ref_clk,
   input  wire logic        rst,
   input  wire logic        sclk,
   input  wire logic        cs_n,
   input  wire logic [3:0]  io_in,
   output logic      [3:0]  io_out,
   output logic      [3:0]  io_oe_n,
   input  wire logic        write_enable_latch,
   input  wire logic        quad_io_enable,
   input  wire logic [2:0]  otp_area_lock_bits,
   input  wire logic [3:0]  status_dummy_clocks,
   input  wire logic [7:0]  array_rd_data,
   output logic      [23:0] array_rd_addr,
   output logic             array_rd_en,
   output logic             four_wire_command_mode,
   output logic      [1:0]  dummy_count_field,
   output logic      [1:0]  wrap_length_field,
   output logic      [3:0]  single_edge_dummy,
   output logic      [3:0]  double_edge_dummy,
   output logic      [6:0]  wrap_bytes,
   output logic             wel_clear,
   output logic             suspend_clear
);
   logic [2:0]    sclk_s;
   logic [2:0]    cs_s;
   logic [3:0]    io_s [3];
   logic          sclk_lvl;
   logic          cs_lvl;
   logic          rise;
   logic          fall;
   logic          cs_up;
   oqr_state_type state;
   oqr_kind_type  kind;
   logic [31:0]   sr;
   logic [31:0]   next_sr;
   logic [5:0]    cnt;
   logic [5:0]    next_cnt;
   logic [23:0]   addr;
   logic [23:0]   mask;
   logic [3:0]    dummy_left;
   logic [3:0]    nib_left;
   logic [7:0]    out_sr;
   logic          rst_armed;
   logic          soft_rst;
   logic          fetch;
   logic          area_ok;
   logic [7:0]    data_byte;
   logic [7:0]    mem_q;
   logic          push_valid;
   oqr_wr_type    push_data;
   logic          push_ready;
   logic          bw_valid;
   logic          bw_ready;
   oqr_wr_type    bw_data;
   logic [3:0]    qpi_dummy;

   // 2'b00 means no area
   function automatic logic [1:0] area_of(input logic [23:0] a);
      if (a[23:`OQR_ADDR_HI_POS] == 8'h00 && a[11:10] == 2'b00 &&
          a[15:12] >= 4'h1 && a[15:12] <= 4'h3) begin
         return a[13:12];
      end
      return 2'b00;
   endfunction : area_of

   function automatic logic [23:0] next_addr(input logic [23:0] a, input logic [23:0] m);
      return (a & ~m) | ((a + 24'h000001) & m);
   endfunction : next_addr

   // pin sampling: three stages, a level counts once stages two and three agree
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         sclk_s   <= 3'h0;
         cs_s     <= 3'h7;
         io_s[0]  <= 4'h0;
         io_s[1]  <= 4'h0;
         io_s[2]  <= 4'h0;
         sclk_lvl <= 1'b0;
         cs_lvl   <= 1'b1;
      end else begin
         sclk_s  <= {sclk_s[1:0], sclk};
         cs_s    <= {cs_s[1:0], cs_n};
         io_s[0] <= io_in;
         io_s[1] <= io_s[0];
         io_s[2] <= io_s[1];
         if (sclk_s[1] == sclk_s[2]) begin
            sclk_lvl <= sclk_s[2];
         end
         if (cs_s[1] == cs_s[2]) begin
            cs_lvl <= cs_s[2];
         end
      end
   end

   assign rise  = sclk_s[1] == sclk_s[2] && sclk_s[2] && !sclk_lvl && !cs_lvl;
   assign fall  = sclk_s[1] == sclk_s[2] && !sclk_s[2] && sclk_lvl && !cs_lvl;
   assign cs_up = cs_s[1] == cs_s[2] && cs_s[2] && !cs_lvl;

   // four bits per edge in four-wire mode, one on the serial input otherwise
   assign next_sr  = four_wire_command_mode ? {sr[27:0], io_s[2]}
                                            : {sr[30:0], io_s[2][0]};
   assign next_cnt = cnt + (four_wire_command_mode ? 6'h04 : 6'h01);
   assign qpi_dummy = {dummy_count_field, 1'b0} + 4'h2;
   assign area_ok  = area_of(addr) != 2'b00;
   assign data_byte = kind != K_OTP ? array_rd_data :
                      area_ok ? mem_q : 8'hff;

   // link state machine: rising edges collect, falling edges drive
   always_ff @(posedge ref_clk) begin
      if (rst || cs_up) begin
         state      <= ST_OPCODE;
         cnt        <= 6'h00;
         nib_left   <= 4'h0;
         io_oe_n    <= 4'hf;
         io_out     <= 4'h0;
         fetch      <= 1'b0;
      end else begin
         fetch <= 1'b0;
         if (rise) begin
            sr  <= next_sr;
            cnt <= next_cnt;
            case (state)
               ST_OPCODE: begin
                  if (next_cnt == `OQR_OPCODE_BITS) begin
                     cnt <= 6'h00;
                     case (next_sr[7:0])
                        `OQR_OP_PROG_OTP: begin
                           kind  <= K_PROG;
                           state <= (!four_wire_command_mode && write_enable_latch) ?
                                    ST_ADDR : ST_IGNORE;
                        end
                        `OQR_OP_READ_OTP: begin
                           kind  <= K_OTP;
                           state <= four_wire_command_mode ? ST_IGNORE : ST_ADDR;
                        end
                        `OQR_OP_FAST_READ: begin
                           kind  <= K_FAST;
                           state <= ST_ADDR;
                        end
                        `OQR_OP_QIO_READ: begin
                           kind  <= K_FAST;
                           state <= four_wire_command_mode ? ST_ADDR : ST_IGNORE;
                        end
                        `OQR_OP_WRAP_READ: begin
                           kind  <= K_WRAP;
                           state <= four_wire_command_mode ? ST_ADDR : ST_IGNORE;
                        end
                        `OQR_OP_SET_PARAM: begin
                           state <= four_wire_command_mode ? ST_PARAM : ST_IGNORE;
                        end
                        default: begin
                           state <= ST_IGNORE;
                        end
                     endcase
                  end
               end
               ST_ADDR: begin
                  if (next_cnt == `OQR_ADDR_BITS) begin
                     cnt  <= 6'h00;
                     addr <= next_sr[23:0];
                     case (kind)
                        K_PROG: begin
                           mask  <= `OQR_OTP_MASK;
                           state <= (area_of(next_sr[23:0]) != 2'b00 &&
                                    !otp_area_lock_bits[area_of(next_sr[23:0]) - 2'h1]) ?
                                    ST_PDATA : ST_IGNORE;
                        end
                        K_OTP: begin
                           mask       <= `OQR_OTP_MASK;
                           dummy_left <= `OQR_OTP_DUMMY;
                           state      <= ST_DUMMY;
                        end
                        K_WRAP: begin
                           mask       <= {17'h0, wrap_bytes - 7'h01};
                           dummy_left <= qpi_dummy;
                           state      <= ST_DUMMY;
                        end
                        default: begin
                           mask       <= `OQR_FULL_MASK;
                           dummy_left <= four_wire_command_mode ? qpi_dummy
                                                                : status_dummy_clocks;
                           state      <= ST_DUMMY;
                        end
                     endcase
                  end
               end
               ST_DUMMY: begin
                  dummy_left <= dummy_left - 4'h1;
                  if (dummy_left <= 4'h1) begin
                     state <= ST_RDATA;
                     fetch <= 1'b1;
                  end
               end
               ST_PDATA: begin
                  if (next_cnt == `OQR_OPCODE_BITS) begin
                     cnt  <= 6'h00;
                     addr <= next_addr(addr, mask);
                  end
               end
               ST_PARAM: begin
                  if (next_cnt == `OQR_OPCODE_BITS) begin
                     state <= ST_IGNORE;
                  end
               end
               default: begin
               end
            endcase
         end else if (fall && state == ST_RDATA) begin
            if (nib_left == 4'h0) begin
               // msb first; address steps once the byte is taken
               nib_left <= four_wire_command_mode ? 4'h1 : 4'h7;
               out_sr   <= four_wire_command_mode ? {data_byte[3:0], 4'h0}
                                                  : {data_byte[6:0], 1'b0};
               io_out   <= four_wire_command_mode ? data_byte[7:4]
                                                  : {2'b00, data_byte[7], 1'b0};
               io_oe_n  <= four_wire_command_mode ? 4'h0 : 4'hd;
               addr     <= next_addr(addr, mask);
               fetch    <= 1'b1;
            end else begin
               nib_left <= nib_left - 4'h1;
               out_sr   <= four_wire_command_mode ? {out_sr[3:0], 4'h0}
                                                  : {out_sr[6:0], 1'b0};
               io_out   <= four_wire_command_mode ? out_sr[7:4]
                                                  : {2'b00, out_sr[7], 1'b0};
            end
         end
      end
   end

   // mode and read parameters; ffh leaves every other setting alone
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         four_wire_command_mode <= 1'b0;
         dummy_count_field      <= `OQR_DEF_DUMMY;
         wrap_length_field      <= `OQR_DEF_WRAP;
         rst_armed              <= 1'b0;
         soft_rst               <= 1'b0;
         wel_clear              <= 1'b0;
         suspend_clear          <= 1'b0;
      end else begin
         soft_rst      <= 1'b0;
         wel_clear     <= 1'b0;
         suspend_clear <= 1'b0;
         if (rise && !cs_lvl && state == ST_OPCODE && next_cnt == `OQR_OPCODE_BITS) begin
            rst_armed <= next_sr[7:0] == `OQR_OP_RST_ENABLE;
            if (next_sr[7:0] == `OQR_OP_RST_DEVICE && rst_armed) begin
               four_wire_command_mode <= 1'b0;
               dummy_count_field      <= `OQR_DEF_DUMMY;
               wrap_length_field      <= `OQR_DEF_WRAP;
               soft_rst               <= 1'b1;
               wel_clear              <= 1'b1;
               suspend_clear          <= 1'b1;
            end else if (next_sr[7:0] == `OQR_OP_ENTER_QPI && !four_wire_command_mode &&
                         quad_io_enable) begin
               four_wire_command_mode <= 1'b1;
               wrap_length_field      <= `OQR_DEF_WRAP;
               wel_clear              <= 1'b1;
               suspend_clear          <= 1'b1;
            end else if (next_sr[7:0] == `OQR_OP_EXIT_QPI && four_wire_command_mode) begin
               four_wire_command_mode <= 1'b0;
            end
         end else if (rise && !cs_lvl && state == ST_PARAM &&
                      next_cnt == `OQR_OPCODE_BITS) begin
            dummy_count_field <= next_sr[`OQR_DUMMY_POS +: 2];
            wrap_length_field <= next_sr[`OQR_WRAP_POS +: 2];
         end
      end
   end

   // decoded read parameters, kept in flops so the outputs are registered
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         single_edge_dummy <= 4'h2;
         double_edge_dummy <= 4'h4;
         wrap_bytes        <= 7'h08;
      end else begin
         single_edge_dummy <= qpi_dummy;
         double_edge_dummy <= qpi_dummy + 4'h2;
         wrap_bytes        <= 7'h08 << wrap_length_field;
      end
   end

   // array read requests and programming bytes toward the otp store
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         array_rd_en   <= 1'b0;
         array_rd_addr <= 24'h0;
         push_valid    <= 1'b0;
         push_data     <= '0;
      end else begin
         array_rd_en <= fetch && kind != K_OTP;
         if (fetch) begin
            array_rd_addr <= addr;
         end
         if (push_valid && push_ready) begin
            push_valid <= 1'b0;
         end
         // a byte waits here while the buffer is full
         if (rise && !cs_lvl && state == ST_PDATA && next_cnt == `OQR_OPCODE_BITS) begin
            push_valid <= 1'b1;
            push_data  <= '{addr: {area_of(addr) - 2'h1, addr[9:0]}, data: next_sr[7:0]};
         end
      end
   end

   oqr_buf2 u_buf (
      .ref_clk   (ref_clk),
      .rst       (rst),
      .in_valid  (push_valid),
      .in_ready  (push_ready),
      .in_data   (push_data),
      .out_valid (bw_valid),
      .out_ready (bw_ready),
      .out_data  (bw_data)
   );

   oqr_otp_mem u_mem (
      .ref_clk  (ref_clk),
      .rd_en    (fetch && kind == K_OTP),
      .rd_addr  ({area_of(addr) - 2'h1, addr[9:0]}),
      .rd_data  (mem_q),
      .wr_valid (bw_valid),
      .wr_ready (bw_ready),
      .wr       (bw_data)
   );

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   property p_enter_needs_qe;
      $rose(four_wire_command_mode) |-> $past(quad_io_enable);
   endproperty
   a_enter_needs_qe: assert property (p_enter_needs_qe) else $error("mode entered without qe");

   property p_enter_clears;
      $rose(four_wire_command_mode) |-> wel_clear && suspend_clear && wrap_length_field == 2'h0;
   endproperty
   a_enter_clears: assert property (p_enter_clears) else $error("entry left settings");

   property p_exit_keeps;
      $fell(four_wire_command_mode) && !soft_rst |-> $stable(wrap_length_field) && !wel_clear;
   endproperty
   a_exit_keeps: assert property (p_exit_keeps) else $error("exit changed settings");

   property p_param_qpi_only;
      $changed(dummy_count_field) && !soft_rst |-> $past(four_wire_command_mode);
   endproperty
   a_param_qpi_only: assert property (p_param_qpi_only) else $error("param in serial mode");

   property p_dummy_map;
      ##1 single_edge_dummy == {$past(dummy_count_field), 1'b0} + 4'h2 &&
          double_edge_dummy == {$past(dummy_count_field), 1'b0} + 4'h4;
   endproperty
   a_dummy_map: assert property (p_dummy_map) else $error("dummy map wrong");

   property p_wrap_map;
      ##1 wrap_bytes == (7'h08 << $past(wrap_length_field));
   endproperty
   a_wrap_map: assert property (p_wrap_map) else $error("wrap map wrong");

   property p_soft_reset;
      soft_rst |-> !four_wire_command_mode && dummy_count_field == 2'h0 &&
                   wrap_length_field == 2'h0 ##2 wrap_bytes == 7'h08;
   endproperty
   a_soft_reset: assert property (p_soft_reset) else $error("reset left settings");

   property p_lock;
      $rose(push_valid) |-> !otp_area_lock_bits[push_data.addr[11:10]] && write_enable_latch;
   endproperty
   a_lock: assert property (p_lock) else $error("locked area written");

   property p_out_of_area;
      state == ST_RDATA && kind == K_OTP && !area_ok |-> data_byte == 8'hff;
   endproperty
   a_out_of_area: assert property (p_out_of_area) else $error("bad area not ffh");

   property p_drive_only_read;
      io_oe_n != 4'hf |-> state == ST_RDATA ##1 (state == ST_RDATA || io_oe_n == 4'hf);
   endproperty
   a_drive_only_read: assert property (p_drive_only_read) else $error("drove outside read");

   property p_cs_ends;
      cs_up |=> io_oe_n == 4'hf && state == ST_OPCODE;
   endproperty
   a_cs_ends: assert property (p_cs_ends) else $error("read outlived chip select");

   c_enter: cover property ($rose(four_wire_command_mode));
   c_prog: cover property (bw_valid && bw_ready);
   c_read: cover property (fetch && kind == K_OTP);
   c_wrap: cover property (fetch && kind == K_WRAP);
   c_reset: cover property (soft_rst);
endmodule : oqr_seq

// ===== verilog/oqr_map.svh
// offsets, opcodes, reset values and counts of the otp / read-parameter sequencer
`ifndef OQR_MAP_SVH
`define OQR_MAP_SVH
`define OQR_OP_PROG_OTP   8'h42
`define OQR_OP_READ_OTP   8'h48
`define OQR_OP_SET_PARAM  8'hc0
`define OQR_OP_FAST_READ  8'h0b
`define OQR_OP_QIO_READ   8'heb
`define OQR_OP_WRAP_READ  8'h0c
`define OQR_OP_ENTER_QPI  8'h38
`define OQR_OP_EXIT_QPI   8'hff
`define OQR_OP_RST_ENABLE 8'h66
`define OQR_OP_RST_DEVICE 8'h99
`define OQR_ADDR_HI_POS   16
`define OQR_AREA_POS      12
`define OQR_DUMMY_POS     4
`define OQR_WRAP_POS      0
`define OQR_DEF_DUMMY     2'h0
`define OQR_DEF_WRAP      2'h0
`define OQR_OTP_DUMMY     4'h8
`define OQR_OTP_MASK      24'h0003ff
`define OQR_FULL_MASK     24'hffffff
`define OQR_OPCODE_BITS   6'h08
`define OQR_ADDR_BITS     6'h18
`endif

// ===== verilog/oqr_pkg.sv
// types shared by the otp / read-parameter sequencer
package oqr_pkg;
   typedef enum logic [2:0] {
      ST_OPCODE = 3'b000,
      ST_ADDR   = 3'b001,
      ST_DUMMY  = 3'b010,
      ST_RDATA  = 3'b011,
      ST_PDATA  = 3'b100,
      ST_PARAM  = 3'b101,
      ST_IGNORE = 3'b110
   } oqr_state_type;
   typedef enum logic [1:0] {
      K_OTP  = 2'b00,
      K_PROG = 2'b01,
      K_FAST = 2'b10,
      K_WRAP = 2'b11
   } oqr_kind_type;
   typedef struct packed {
      logic [11:0] addr;
      logic [7:0]  data;
   } oqr_wr_type;
endpackage : oqr_pkg

// ===== verilog/oqr_otp_mem.sv
// otp byte store: registered read, program only clears bits
`timescale 1ns/1ps
module oqr_otp_mem import oqr_pkg::*; #(
   parameter int DEPTH = 3072
) (
   input  wire logic       ref_clk,
   input  wire logic       rd_en,
   input  wire logic [11:0] rd_addr,
   output logic      [7:0]  rd_data,
   input  wire logic       wr_valid,
   output logic            wr_ready,
   input  wire oqr_wr_type wr
);
   logic [7:0] mem [DEPTH];

   // three areas of 1024 bytes must fit below the 12-bit index
   if (DEPTH < 3072 || DEPTH > 4096) begin : g_chk
      $error("oqr_otp_mem: depth out of range");
   end

   // models erased cells; a real otp keeps its contents over power
   initial begin
      for (int i = 0; i < DEPTH; i++) begin
         mem[i] = 8'hff;
      end
   end

   // a read in flight has priority, the write waits one cycle
   assign wr_ready = !rd_en;

   always_ff @(posedge ref_clk) begin
      if (rd_en) begin
         rd_data <= mem[rd_addr];
      end
   end

   always_ff @(posedge ref_clk) begin
      if (wr_valid && wr_ready) begin
         mem[wr.addr] <= mem[wr.addr] & wr.data;
      end
   end
endmodule : oqr_otp_mem

// ===== verilog/oqr_buf2.sv
// two-entry buffer with valid/ready on both sides
`timescale 1ns/1ps
module oqr_buf2 import oqr_pkg::*; (
   input  wire logic       ref_clk,
   input  wire logic       rst,
   input  wire logic       in_valid,
   output logic            in_ready,
   input  wire oqr_wr_type in_data,
   output logic            out_valid,
   input  wire logic       out_ready,
   output oqr_wr_type      out_data
);
   oqr_wr_type slot [2];
   logic       rd_ptr;
   logic       wr_ptr;
   logic [1:0] count;
   logic       push;
   logic       pop;

   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;
   assign in_ready  = count != 2'h2;
   assign out_valid = count != 2'h0;
   assign out_data  = slot[rd_ptr];

   always_ff @(posedge ref_clk) begin
      if (push) begin
         slot[wr_ptr] <= in_data;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         rd_ptr <= 1'b0;
         wr_ptr <= 1'b0;
         count  <= 2'h0;
      end else begin
         if (push) begin
            wr_ptr <= !wr_ptr;
         end
         if (pop) begin
            rd_ptr <= !rd_ptr;
         end
         count <= count + {1'b0, push} - {1'b0, pop};
      end
   end
endmodule : oqr_buf2

// ===== bench/oqr_host.sv
// host controller model: chip select, link clock, data pins
`timescale 1ns/1ps
module oqr_host (
   output logic            sclk,
   output logic            cs_n,
   output logic      [3:0] io,
   input  wire logic [3:0] dq
);
   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      io   = 4'h5;
   end
   // sclk stands low between frames
   task automatic tick;
      #31.25 sclk = 1'b1;
      #62.5 sclk = 1'b0;
      #31.25;
   endtask : tick
   task automatic put(input logic [31:0] v, input int n, input bit q);
      for (int i = n - 1; i >= 0; i -= q ? 4 : 1) begin // msb first
         io = q ? v[i-:4] : {~io[3:1], v[i]};
         tick;
      end
   endtask : put
   // released lines toggle so a stale value never passes
   task automatic get(output logic [7:0] b, input bit q);
      for (int i = 0; i < (q ? 2 : 8); i++) begin
         io = ~io;
         #31.25 sclk = 1'b1;
         b = q ? {b[3:0], dq} : {b[6:0], dq[1]};
         #62.5 sclk = 1'b0;
         #31.25;
      end
   endtask : get
   task automatic start;
      cs_n = 1'b0; // low over the whole instruction
      #31.25;
   endtask : start
   task automatic stop;
      cs_n = 1'b1; // rising chip select ends a read
      io = ~io;
      #200;
   endtask : stop
endmodule : oqr_host

// ===== bench/otp_area_and_qpi_read_config_tb_top.sv
// self-checking bench of the otp / read-parameter sequencer
`timescale 1ns/1ps
module otp_area_and_qpi_read_config_tb_top;
   logic        ref_clk, rst, sclk, cs_n, wel_clear, suspend_clear;
   logic        write_enable_latch, quad_io_enable, four_wire_command_mode;
   logic [1:0]  dummy_count_field;
   logic [1:0]  seen = 2'h0;
   logic [2:0]  otp_area_lock_bits = 3'h0;
   logic [3:0]  io, io_out, io_oe_n, single_edge_dummy, double_edge_dummy;
   logic [3:0]  status_dummy_clocks = 4'h8;
   logic [6:0]  wrap_bytes;
   logic [23:0] array_rd_addr;
   int          errors = 0;
   int          checked = 0;
   logic [7:0]  array_rd_data = 8'h0;
   logic        array_rd_en;
   logic [1:0]  wrap_length_field;
   oqr_seq dut_u (
      .ref_clk, .rst, .sclk, .cs_n, .io_in(io), .io_out, .io_oe_n,
      .write_enable_latch, .quad_io_enable, .otp_area_lock_bits,
      .status_dummy_clocks, .array_rd_data, .array_rd_addr, .array_rd_en,
      .four_wire_command_mode, .dummy_count_field, .wrap_length_field,
      .single_edge_dummy, .double_edge_dummy, .wrap_bytes, .wel_clear,
      .suspend_clear
   );
   oqr_host host_u (.sclk, .cs_n, .io, .dq(io_out));
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   // cleared in reset so an unknown pulse level before reset cannot stick
   always @(posedge ref_clk) seen <= rst ? 2'h0 : seen | {wel_clear, suspend_clear};
   // array stand-in answers only after a read strobe
   always @(posedge ref_clk) if (array_rd_en) array_rd_data <= array_rd_addr[7:0];
   task chk(input string n, input logic [7:0] e, input logic [7:0] g);
      checked++;
      if (g !== e) begin
         errors++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task frame(input logic [7:0] op, input logic [31:0] a, input int n, input bit q);
      host_u.start();
      host_u.put({24'h0, op}, 8, q);
      host_u.put(a, n, q);
   endtask : frame
   task cmd(input logic [7:0] op, input bit q);
      frame(op, 32'h0, 0, q);
      host_u.stop();
   endtask : cmd
   task setp(input logic [7:0] p, input bit q);
      frame(8'hc0, {24'h0, p}, 8, q);
      host_u.stop();
   endtask : setp
   task pg(input logic [23:0] a, input logic [15:0] d, input int n);
      frame(8'h42, {8'h0, a}, 24, 0);
      host_u.put({16'h0, d}, n, 0);
      host_u.stop();
   endtask : pg
   task rd(input logic [23:0] a, input logic [7:0] e0, input logic [7:0] e1);
      logic [7:0] b;
      frame(8'h48, {8'h0, a}, 24, 0);
      host_u.put(32'h0, 8, 0); // eight dummy clocks
      host_u.get(b, 0);
      chk("otp0", e0, b);
      host_u.get(b, 0);
      chk("otp1", e1, b);
      chk("oe", 8'h0d, {4'h0, io_oe_n});
      host_u.stop();
      chk("oe", 8'h0f, {4'h0, io_oe_n});
   endtask : rd
   task rdq(input logic [7:0] op, input logic [23:0] a, input int d, input logic [7:0] e0,
            input logic [7:0] e1);
      logic [7:0] b;
      frame(op, {8'h0, a}, 24, 1);
      host_u.put(32'h0, 4 * d, 1); // programmed dummy clocks
      host_u.get(b, 1);
      chk("qrd0", e0, b);
      host_u.get(b, 1);
      chk("qrd1", e1, b);
      chk("qoe", 8'h00, {4'h0, io_oe_n});
      host_u.stop();
   endtask : rdq
   task t_defaults;
      chk("mode", 8'h00, {7'h0, four_wire_command_mode});
      chk("single", 8'h02, {4'h0, single_edge_dummy});
      chk("double", 8'h04, {4'h0, double_edge_dummy});
      chk("wrap", 8'h08, {1'b0, wrap_bytes});
   endtask : t_defaults
   task t_otp;
      @(posedge ref_clk);
      #1 write_enable_latch = 1'b1;
      otp_area_lock_bits = 3'h2;
      pg(24'h0013ff, 16'h3cc3, 16); // erased cells only
      pg(24'h002000, 16'h0000, 8);
      @(posedge ref_clk);
      #1 write_enable_latch = 1'b0;
      pg(24'h001002, 16'h0000, 8);
      rd(24'h0013ff, 8'h3c, 8'hc3);
      rd(24'h002000, 8'hff, 8'hff);
      rd(24'h001001, 8'hff, 8'hff);
      rd(24'h001400, 8'hff, 8'hff);
   endtask : t_otp
   task t_mode;
      setp(8'h33, 0);
      chk("dummy", 8'h00, {6'h0, dummy_count_field});
      cmd(8'h38, 0);
      chk("mode", 8'h00, {7'h0, four_wire_command_mode});
      chk("clears", 8'h00, {6'h0, seen});
      @(posedge ref_clk);
      #1 quad_io_enable = 1'b1;
      cmd(8'h38, 0);
      chk("mode", 8'h01, {7'h0, four_wire_command_mode});
      chk("clears", 8'h03, {6'h0, seen});
   endtask : t_mode
   task t_param;
      for (int f = 0; f < 4; f++) begin
         setp(8'(f * 8'h11), 1); // nibble transfers
         chk("single", 8'(2 + 2 * f), {4'h0, single_edge_dummy});
         chk("double", 8'(4 + 2 * f), {4'h0, double_edge_dummy});
         chk("wrap", 8'(8 << f), {1'b0, wrap_bytes});
         chk("wrapf", 8'(f), {6'h0, wrap_length_field});
      end
      rdq(8'h0c, 24'h00013f, 8, 8'h3f, 8'h00);
      rdq(8'h0b, 24'h00013f, 8, 8'h3f, 8'h40);
      cmd(8'hff, 1);
      chk("mode", 8'h00, {7'h0, four_wire_command_mode});
      chk("wrap", 8'h40, {1'b0, wrap_bytes});
      cmd(8'h66, 0);
      cmd(8'h99, 0);
      chk("wrap", 8'h08, {1'b0, wrap_bytes});
      chk("single", 8'h02, {4'h0, single_edge_dummy});
   endtask : t_param
   task close_out;
      $display("errors %0d checked %0d", errors, checked);
      if (errors == 0 && checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : close_out
   initial begin
      rst = 1'b1;
      write_enable_latch = 1'b0;
      quad_io_enable = 1'b0;
      repeat (12) @(posedge ref_clk);
      #1 rst = 1'b0;
      t_defaults;
      t_otp;
      t_mode;
      t_param;
      close_out;
   end
endmodule : otp_area_and_qpi_read_config_tb_top
